// >>> pkg/clb_pkg.sv
// Constants, types and reset values for the configuration latch bank.
// Assumes one system clock; the host pins arrive asynchronously.

package clb_pkg;

	localparam int CLB_NUM_BANKS      = 16;
	localparam int CLB_NUM_CHAN_BANKS = 12;
	localparam int CLB_BANKS_PER_CHAN = 3;
	localparam int CLB_NUM_CHAN       = 4;
	localparam int CLB_DATA_W         = 8;
	localparam int CLB_ADDR_W         = 4;

	localparam logic [3:0] CLB_BANK_BCAST_RX  = 4'hc;
	localparam logic [3:0] CLB_BANK_BCAST_TX  = 4'hd;
	localparam logic [3:0] CLB_BANK_BCAST_DYN = 4'he;
	localparam logic [3:0] CLB_BANK_MASK      = 4'hf;

	localparam int CLB_ENABLE_BIT = 0;
	localparam int CLB_FORCE_BIT  = 0;

	localparam logic [7:0] CLB_CHAN_BANK_RST = 8'h01;
	localparam logic [7:0] CLB_BCAST_RST     = 8'h00;
	localparam logic [7:0] CLB_MASK_RST      = 8'hff;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
		logic       strobe_n;
	} clb_pin_t;

	typedef struct packed {
		logic [7:0] rx_static;
		logic [7:0] tx_static;
		logic [7:0] dynamic;
	} clb_chan_cfg_t;

endpackage

// >>> verilog/clb_bank_cell.sv
// One per-channel latch bank with bit mask and broadcast update.
// Assumes write requests arrive already synchronised to clk_sys_in.
`timescale 1ns/100ps

module clb_bank_cell
	import clb_pkg::*;
#(
	parameter logic [7:0] RST_VAL = CLB_CHAN_BANK_RST
)
(
	input  wire logic       clk_sys_in,   // System clock
	input  wire logic       resetn_in,    // Synchronous reset, active low
	input  wire logic       direct_wr_in, // Bank addressed directly
	input  wire logic       bcast_wr_in,  // Broadcast copy allowed
	input  wire logic [7:0] mask_in,      // Bit update mask
	input  wire logic [7:0] data_in,      // Write data
	output logic      [7:0] bank_out      // Stored bank value
);

	logic [7:0] next_bank;
	logic [7:0] eff_mask;

	always_comb
	begin
		eff_mask = mask_in;
		if (!direct_wr_in)
		begin
			eff_mask[CLB_ENABLE_BIT] = 1'b0;
		end
		next_bank = (bank_out & ~eff_mask) | (data_in & eff_mask);
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!resetn_in)
		begin
			bank_out <= RST_VAL;
		end
		else if (direct_wr_in || bcast_wr_in)
		begin
			bank_out <= next_bank;
		end
	end

endmodule // clb_bank_cell

// >>> verilog/clb_config_latch.sv
// Write-only configuration latch bank: sixteen banks behind a strobed
// address/data pin interface. Assumes the host pins are asynchronous to
// clk_sys_in and held stable for at least three clock cycles per write.
`timescale 1ns/100ps

module clb_config_latch
	import clb_pkg::*;
(
	input  wire logic              clk_sys_in,       // System clock
	input  wire logic              resetn_in,        // Sync reset, low
	input  wire logic [3:0]        bank_addr_in,     // Bank address pins
	input  wire logic [7:0]        bank_data_in,     // Bank data pins
	input  wire logic              latch_write_strobe_n_in, // Strobe, low
	output clb_chan_cfg_t          chan_cfg_out [CLB_NUM_CHAN], // Banks
	output logic      [2:0][7:0]   bcast_bank_out,   // Banks 12 to 14
	output logic      [7:0]        mask_out,         // Bank 15
	output logic      [2:0]        force_broadcast_update_out, // Force
	output logic      [11:0]       bank_broadcast_enable_out,  // Enables
	output logic      [15:0]       bank_update_out,  // Bank written pulse
	output logic                   write_active_out  // Write taken level
);

	// Pin synchroniser and stability stage
	clb_pin_t pin_now;
	clb_pin_t pin_meta;
	clb_pin_t pin_sync;
	clb_pin_t pin_hold;

	logic       wr_take;
	logic [3:0] wr_addr;
	logic [7:0] wr_data;

	logic [15:0] direct_sel;
	logic [2:0]  bcast_sel;
	logic        mask_sel;

	logic [2:0][7:0] bcast_bank;
	logic [2:0]      force_now;
	logic [7:0]      mask_bank;

	logic [11:0][7:0] chan_bank;
	logic [11:0]      cell_direct;
	logic [11:0]      cell_bcast;

	logic [15:0] next_update;

	assign pin_now.addr     = bank_addr_in;
	assign pin_now.data     = bank_data_in;
	assign pin_now.strobe_n = latch_write_strobe_n_in;

	// First stage feeds only the second
	always_ff @(posedge clk_sys_in)
	begin
		if (!resetn_in)
		begin
			pin_meta <= '{addr: '0, data: '0, strobe_n: 1'b1};
		end
		else
		begin
			pin_meta <= pin_now;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!resetn_in)
		begin
			pin_sync <= '{addr: '0, data: '0, strobe_n: 1'b1};
		end
		else
		begin
			pin_sync <= pin_meta;
		end
	end

	// Third copy lets a skewed bus settle before it is used
	always_ff @(posedge clk_sys_in)
	begin
		if (!resetn_in)
		begin
			pin_hold <= '{addr: '0, data: '0, strobe_n: 1'b1};
		end
		else
		begin
			pin_hold <= pin_sync;
		end
	end

	// Level sensitive: a held strobe rewrites every cycle
	always_comb
	begin
		wr_take = !pin_sync.strobe_n && (pin_sync == pin_hold);
		wr_addr = pin_sync.addr;
		wr_data = pin_sync.data;
	end

	// Address decode
	always_comb
	begin
		direct_sel = '0;
		if (wr_take)
		begin
			direct_sel[wr_addr] = 1'b1;
		end
		bcast_sel[0] = direct_sel[CLB_BANK_BCAST_RX];
		bcast_sel[1] = direct_sel[CLB_BANK_BCAST_TX];
		bcast_sel[2] = direct_sel[CLB_BANK_BCAST_DYN];
		mask_sel     = direct_sel[CLB_BANK_MASK];
	end

	// Force bits take effect in the same write that sets them
	always_comb
	begin
		for (int g = 0; g < CLB_BANKS_PER_CHAN; g++)
		begin
			if (bcast_sel[g])
			begin
				force_now[g] = wr_data[CLB_FORCE_BIT];
			end
			else
			begin
				force_now[g] = bcast_bank[g][CLB_FORCE_BIT];
			end
		end
	end

	// Broadcast banks 12 to 14; force bit ignores mask bit 0
	genvar gb;
	generate
		for (gb = 0; gb < CLB_BANKS_PER_CHAN; gb++)
		begin : g_bcast
			logic [7:0] bmask;
			logic [7:0] next_bcast;

			always_comb
			begin
				bmask = mask_bank;
				bmask[CLB_FORCE_BIT] = 1'b1;
				next_bcast = (bcast_bank[gb] & ~bmask) | (wr_data & bmask);
			end

			always_ff @(posedge clk_sys_in)
			begin
				if (!resetn_in)
				begin
					bcast_bank[gb] <= CLB_BCAST_RST;
				end
				else if (bcast_sel[gb])
				begin
					bcast_bank[gb] <= next_bcast;
				end
			end
		end
	endgenerate

	// Mask bank is never masked by itself
	always_ff @(posedge clk_sys_in)
	begin
		if (!resetn_in)
		begin
			mask_bank <= CLB_MASK_RST;
		end
		else if (mask_sel)
		begin
			mask_bank <= wr_data;
		end
	end

	// Per-channel banks 0 to 11
	genvar gc;
	generate
		for (gc = 0; gc < CLB_NUM_CHAN_BANKS; gc++)
		begin : g_chan
			localparam int GROUP = gc % CLB_BANKS_PER_CHAN;

			assign cell_direct[gc] = direct_sel[gc];
			// Broadcast group member, enabled or forced
			assign cell_bcast[gc]  = bcast_sel[GROUP]
				&& (chan_bank[gc][CLB_ENABLE_BIT]
				|| force_now[GROUP]);

			clb_bank_cell #(
				.RST_VAL      (CLB_CHAN_BANK_RST)
			) u_cell (
				.clk_sys_in   (clk_sys_in),
				.resetn_in    (resetn_in),
				.direct_wr_in (cell_direct[gc]),
				.bcast_wr_in  (cell_bcast[gc]),
				.mask_in      (mask_bank),
				.data_in      (wr_data),
				.bank_out     (chan_bank[gc])
			);
		end
	endgenerate

	// Which banks a write touches this cycle
	always_comb
	begin
		next_update = '0;
		for (int b = 0; b < CLB_NUM_CHAN_BANKS; b++)
		begin
			next_update[b] = cell_direct[b] || cell_bcast[b];
		end
		next_update[CLB_BANK_BCAST_RX]  = bcast_sel[0];
		next_update[CLB_BANK_BCAST_TX]  = bcast_sel[1];
		next_update[CLB_BANK_BCAST_DYN] = bcast_sel[2];
		next_update[CLB_BANK_MASK]      = mask_sel;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!resetn_in)
		begin
			bank_update_out <= '0;
		end
		else
		begin
			bank_update_out <= next_update;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (!resetn_in)
		begin
			write_active_out <= 1'b0;
		end
		else
		begin
			write_active_out <= wr_take;
		end
	end

	// Outputs straight from the bank flip-flops
	genvar go;
	generate
		for (go = 0; go < CLB_NUM_CHAN; go++)
		begin : g_out
			assign chan_cfg_out[go].rx_static =
				chan_bank[go * CLB_BANKS_PER_CHAN];
			assign chan_cfg_out[go].tx_static =
				chan_bank[go * CLB_BANKS_PER_CHAN + 1];
			assign chan_cfg_out[go].dynamic   =
				chan_bank[go * CLB_BANKS_PER_CHAN + 2];
		end
		for (go = 0; go < CLB_NUM_CHAN_BANKS; go++)
		begin : g_en
			assign bank_broadcast_enable_out[go] =
				chan_bank[go][CLB_ENABLE_BIT];
		end
		for (go = 0; go < CLB_BANKS_PER_CHAN; go++)
		begin : g_force
			assign force_broadcast_update_out[go] =
				bcast_bank[go][CLB_FORCE_BIT];
		end
	endgenerate

	assign bcast_bank_out = bcast_bank;
	assign mask_out       = mask_bank;

endmodule // clb_config_latch

// >>> dv/clb_config_latch_assertions.sv
// Checker for the configuration latch bank top module.
// Assumes it is bound to clb_config_latch and sees only its ports.
`timescale 1ns/100ps

module clb_config_latch_assertions
	import clb_pkg::*;
(
	input wire logic        clk_sys_in,                 // Clock
	input wire logic        resetn_in,                  // Reset, low
	input wire logic [3:0]  bank_addr_in,               // Address
	input wire logic [7:0]  bank_data_in,               // Data
	input wire logic        latch_write_strobe_n_in,    // Strobe
	input wire logic [7:0]  mask_out,                   // Mask
	input wire logic [2:0]  force_broadcast_update_out, // Force
	input wire logic [11:0] bank_broadcast_enable_out,  // Enables
	input wire logic [15:0] bank_update_out,            // Written
	input wire logic        write_active_out            // Taken
);
	default clocking cb @(posedge clk_sys_in);
	endclocking

	// Pins held low and steady for four cycles
	sequence s_held;
		(!latch_write_strobe_n_in && $stable(bank_addr_in)
			&& $stable(bank_data_in))[*4];
	endsequence

	property p_take;
		disable iff (!resetn_in) s_held |-> ##[0:2] write_active_out;
	endproperty
	property p_mask_rst;
		!resetn_in |=> mask_out == 8'hff;
	endproperty
	property p_en_rst;
		!resetn_in |=> bank_broadcast_enable_out == 12'hfff;
	endproperty
	property p_active;
		disable iff (!resetn_in) |bank_update_out |-> write_active_out;
	endproperty
	property p_rx_en;
		disable iff (!resetn_in) bank_update_out[12]
			&& bank_broadcast_enable_out[9] |-> bank_update_out[9];
	endproperty
	property p_rx_off;
		disable iff (!resetn_in) bank_update_out[12]
			&& !force_broadcast_update_out[0]
			&& !bank_broadcast_enable_out[6] |-> !bank_update_out[6];
	endproperty
	property p_tx_en;
		disable iff (!resetn_in) bank_update_out[13]
			&& bank_broadcast_enable_out[4] |-> bank_update_out[4];
	endproperty
	property p_dyn_force;
		disable iff (!resetn_in) bank_update_out[14]
			&& force_broadcast_update_out[2] |-> &{bank_update_out[2],
			bank_update_out[5], bank_update_out[8], bank_update_out[11]};
	endproperty
	property p_en_keep;
		disable iff (!resetn_in) $changed(bank_broadcast_enable_out[1])
			|-> bank_update_out[1] && !bank_update_out[13];
	endproperty
	property p_mask_solo;
		disable iff (!resetn_in) bank_update_out[15]
			|-> bank_update_out[14:0] == 15'h0000;
	endproperty

	a_take: assert property (p_take)
		else $error("held write not taken");
	a_mask_rst: assert property (p_mask_rst)
		else $error("mask not all ones after reset");
	a_en_rst: assert property (p_en_rst)
		else $error("enables not set after reset");
	a_active: assert property (p_active)
		else $error("bank written without a taken write");
	a_rx_en: assert property (p_rx_en)
		else $error("enabled bank missed broadcast");
	a_rx_off: assert property (p_rx_off)
		else $error("disabled bank took broadcast");
	a_tx_en: assert property (p_tx_en)
		else $error("enabled bank missed broadcast");
	a_dyn_force: assert property (p_dyn_force)
		else $error("forced broadcast incomplete");
	a_en_keep: assert property (p_en_keep)
		else $error("enable changed by broadcast");
	a_mask_solo: assert property (p_mask_solo)
		else $error("mask write touched other banks");
endmodule // clb_config_latch_assertions

bind clb_config_latch clb_config_latch_assertions u_chk (
	.clk_sys_in, .resetn_in, .bank_addr_in, .bank_data_in,
	.latch_write_strobe_n_in, .mask_out, .force_broadcast_update_out,
	.bank_broadcast_enable_out, .bank_update_out, .write_active_out);

// >>> dv/clb_host_model.sv
// Host controller model driving the latch bank pins.
// Assumes the caller waits for each task to return.
`timescale 1ns/100ps

module clb_host_model (
	input  wire logic clk_sys_in,            // Clock
	output logic [3:0] bank_addr_out = 4'h0, // Address pins
	output logic [7:0] bank_data_out = 8'h00, // Data pins
	output logic       strobe_n_out = 1'b1   // Strobe, low
);
	// Keep leaves the strobe low so the next call is a live change
	task automatic wr(input logic [3:0] a, input logic [7:0] d,
		input bit keep);
		@(posedge clk_sys_in);
		bank_addr_out <= a;
		bank_data_out <= d;
		strobe_n_out <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		if (!keep)
		begin
			strobe_n_out <= 1'b1;
			bank_data_out <= ~d;
			bank_addr_out <= ~a;
		end
		repeat (4) @(posedge clk_sys_in);
	endtask
endmodule // clb_host_model

// >>> dv/clb_config_latch_bench.sv
// Self-checking bench for the configuration latch bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps

module clb_config_latch_bench import clb_pkg::*;;
	logic          clk_sys_in = 1'b0;
	logic          resetn_in = 1'b0;
	logic [3:0]    addr;
	logic [7:0]    data;
	logic          wr_n;
	clb_chan_cfg_t cfg [CLB_NUM_CHAN];
	logic [2:0][7:0] bc;
	logic [7:0]    mk;
	logic [2:0]    frc;
	logic [11:0]   en;
	logic [15:0]   upd;
	logic          act;
	int            n_fail = 0;
	int            check_count = 0;
	// Address, data, bank to look at, expected value
	logic [23:0] rows [11] = '{24'h15a15a, 24'hc3c33d, 24'h680680,
		24'hcc2680, 24'hd0015a, 24'hd01100, 24'hf0ff0f, 24'hf3cf3c,
		24'h2ff23d, 24'hefd53d, 24'hffffff};

	always #2 clk_sys_in = ~clk_sys_in;

	clb_host_model u_host (.clk_sys_in, .bank_addr_out(addr),
		.bank_data_out(data), .strobe_n_out(wr_n));
	clb_config_latch DUT (.clk_sys_in, .resetn_in, .bank_addr_in(addr),
		.bank_data_in(data), .latch_write_strobe_n_in(wr_n),
		.chan_cfg_out(cfg), .bcast_bank_out(bc), .mask_out(mk),
		.force_broadcast_update_out(frc),
		.bank_broadcast_enable_out(en), .bank_update_out(upd),
		.write_active_out(act));

	function automatic logic [7:0] bank(input logic [3:0] k);
		if (k == 4'hf)
			return mk;
		if (k > 4'hb)
			return bc[k[1:0]];
		case (k % 3)
			0: return cfg[k / 3].rx_static;
			1: return cfg[k / 3].tx_static;
			default: return cfg[k / 3].dynamic;
		endcase
	endfunction

	task chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e)
		begin
			n_fail++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		repeat (4) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		foreach (rows[i])
		begin
			u_host.wr(rows[i][23:20], rows[i][19:12], 1'b0);
			chk(bank(rows[i][11:8]), rows[i][7:0]);
			$display("row %0d done", i);
		end
		u_host.wr(4'he, 8'h40, 1'b1);
		u_host.wr(4'he, 8'h80, 1'b0);
		chk(bank(4'h2), 8'h81);
		chk(bank(4'he), 8'h80);
		chk({5'h00, frc}, 8'h02);
		$display("live control done");
		u_host.wr(4'h9, 8'h00, 1'b0);
		u_host.wr(4'hf, 8'h00, 1'b0);
		chk(bank(4'h9), 8'h00);
		chk(bank(4'hf), 8'h00);
		resetn_in <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		@(posedge clk_sys_in);
		chk(bank(4'h0), 8'h01);
		chk(bank(4'hf), 8'hff);
		chk(en[7:0], 8'hff);
		chk({4'h0, en[11:8]}, 8'h0f);
		$display("reset done");
		wrap_up;
	end

	// Roughly ten times the expected run length
	initial
	begin
		#6400;
		n_fail++;
		wrap_up;
	end
endmodule // clb_config_latch_bench
